/* File: pbsp_pkg.sv */
/*
  Shared constants, state enumerations and carrier types for the
  pipelined burst SRAM port.
  Assumes a single 250 MHz clock and a synchronous active-high reset.
*/
package pbsp_pkg;

  // ----------------------------------------------------------------
  // Geometry defaults
  // ----------------------------------------------------------------
  localparam int ADDR_W_DEF = 18;
  localparam int LANES_DEF  = 4;
  localparam int BYTE_W     = 8;
  localparam int LANE_W     = BYTE_W + 1;
  localparam int BURST_W    = 2;

  // ----------------------------------------------------------------
  // Burst order encodings
  // ----------------------------------------------------------------
  localparam logic ORDER_LINEAR      = 1'b0;
  localparam logic ORDER_INTERLEAVED = 1'b1;
  localparam logic [BURST_W-1:0] BURST_FIRST = 2'h0;
  localparam logic [BURST_W-1:0] BURST_STEP  = 2'h1;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS          = 4;
  localparam int SLEEP_ENTRY_TIME_NS    = 8;
  localparam int SLEEP_RECOVERY_TIME_NS = 8;
  // Longest time rounds down, least time rounds up, floor of one cycle
  localparam int SLEEP_ENTRY_CYC =
    (SLEEP_ENTRY_TIME_NS / CLK_PERIOD_NS < 1) ? 1
    : SLEEP_ENTRY_TIME_NS / CLK_PERIOD_NS;
  localparam int SLEEP_RECOVERY_CYC =
    ((SLEEP_RECOVERY_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS < 1) ? 1
    : (SLEEP_RECOVERY_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SLEEP_CNT_W = 4;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SL_AWAKE,
    SL_ENTER,
    SL_ASLEEP,
    SL_WAKE
  } pbsp_sleep_t;

  typedef struct packed {
    logic valid;
    logic write;
  } pbsp_op_t;

  localparam pbsp_op_t OP_NONE = '{valid: 1'b0, write: 1'b0};

endpackage

/* File: pbsp_burst_addr.sv */
/*
  Burst address sequencer for the two lowest address bits.
  Assumes start and step are stable within the cycle; purely combinational.
*/
`timescale 1ns/1ns
module pbsp_burst_addr #(
  parameter int W = 2
) (
  // Sequence inputs
  input  wire logic [W-1:0] start,
  input  wire logic [W-1:0] step,
  input  wire logic         order,
  // Address of this step
  output logic      [W-1:0] addr_lo
);

  // ----------------------------------------------------------------
  // Linear adds, interleaved flips bits; both wrap within the group
  // ----------------------------------------------------------------
  always_comb begin
    if (order == pbsp_pkg::ORDER_INTERLEAVED) begin
      addr_lo = start ^ step;
    end else begin
      addr_lo = W'(start + step);
    end
  end

endmodule

/* File: pbsp_port.sv */
/*
  Pipelined burst SRAM port: command capture, burst counter, one-cycle
  read pipeline, late-write data phase, byte lane masking, stall and sleep.
  Assumes all pin inputs are synchronous to clk; the bidirectional data
  and parity pins are resolved outside from the output enables.
*/
`timescale 1ns/1ns
// Notes on behaviour
// - Clock gate high ignores the edge; all state holds except the sleep sequencer, which still moves and drops pending ops.
// - Load with all selects active and write select high starts a read.
// - Read data leaves the output register after the next edge.
// - Output enable low plus internal control decides read drive.
// - A new operation may follow a read on the very next edge.
// - A deselect tri-states the outputs after the following edge.
// - Two-bit burst counter gives four accesses, wrapping in its group.
// - Order input low picks linear, high picks interleaved.
// - Linear adds step modulo four; interleaved XORs step into start.
// - Step input high advances the counter, ignoring selects.
// - Direction is latched at load and kept through the burst.
// - Load with all selects active and write select low starts a write.
// - Pins float on the edge after a write address, whatever enable.
// - Write data is taken on the second edge after its address.
// - Only lanes whose mask bit is low, parity included, are written.
// - Sleep input enters low power in two cycles; contents kept.
// - Operations pending at sleep entry are dropped.
// - Sleep input idles low; low means normal operation.
// - Write with all mask bits high writes nothing; pins float.
// - Comes up deselected with outputs off, whatever enable.
module pbsp_port #(
  parameter int ADDR_W = pbsp_pkg::ADDR_W_DEF,
  parameter int LANES  = pbsp_pkg::LANES_DEF
) (
  // Clock and reset
  input  wire logic                   clk,
  input  wire logic                   reset,
  // Command pins
  input  wire logic                   clk_gate_n,
  input  wire logic                   chip_sel_a_n,
  input  wire logic                   chip_sel_b,
  input  wire logic                   chip_sel_c_n,
  input  wire logic                   burst_step_or_load,
  input  wire logic                   write_sel_n,
  input  wire logic [LANES-1:0]       byte_lane_mask_n,
  input  wire logic [ADDR_W-1:0]      addr,
  input  wire logic                   burst_order,
  // Asynchronous controls
  input  wire logic                   out_en_n,
  input  wire logic                   sleep_req,
  // Data pins
  input  wire logic [LANES*8-1:0]     dq_in,
  output logic      [LANES*8-1:0]     dq_out,
  output logic                        dq_oe,
  // Parity pins
  input  wire logic [LANES-1:0]       parity_in,
  output logic      [LANES-1:0]       parity_out,
  output logic                        parity_oe
);

  // ----------------------------------------------------------------
  // Sizes and elaboration checks
  // ----------------------------------------------------------------
  localparam int LW     = pbsp_pkg::LANE_W;
  localparam int BW     = pbsp_pkg::BYTE_W;
  localparam int KW     = pbsp_pkg::BURST_W;
  localparam int WORD_W = LANES * LW;
  localparam int DEPTH  = 1 << ADDR_W;
  localparam int CW     = pbsp_pkg::SLEEP_CNT_W;

  generate
    if (ADDR_W <= KW || ADDR_W > 24) begin : g_bad_addr
      $error("ADDR_W must lie between 3 and 24");
    end
    if (LANES < 1 || LANES > 8) begin : g_bad_lanes
      $error("LANES must lie between 1 and 8");
    end
    if (pbsp_pkg::SLEEP_ENTRY_CYC >= (1 << CW) ||
        pbsp_pkg::SLEEP_RECOVERY_CYC >= (1 << CW)) begin : g_bad_cnt
      $error("Sleep counts exceed counter width");
    end
  endgenerate

  localparam logic [CW-1:0] ENTRY_LAST = CW'(pbsp_pkg::SLEEP_ENTRY_CYC - 1);
  localparam logic [CW-1:0] REC_LAST   = CW'(pbsp_pkg::SLEEP_RECOVERY_CYC - 1);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  pbsp_pkg::pbsp_sleep_t sl_r, sl_nxt;
  logic [CW-1:0]         sl_cnt_r, sl_cnt_nxt;

  logic [ADDR_W-1:0]     base_r, base_nxt;
  logic [KW-1:0]         step_r, step_nxt;
  logic                  order_r, order_nxt;
  pbsp_pkg::pbsp_op_t    burst_r, burst_nxt;

  pbsp_pkg::pbsp_op_t    s1_r, s1_nxt;
  logic [ADDR_W-1:0]     s1_addr_r, s1_addr_nxt;
  logic [LANES-1:0]      s1_mask_r, s1_mask_nxt;
  pbsp_pkg::pbsp_op_t    s2_r, s2_nxt;
  logic [ADDR_W-1:0]     s2_addr_r, s2_addr_nxt;
  logic [LANES-1:0]      s2_mask_r, s2_mask_nxt;

  logic [WORD_W-1:0]     q_r, q_nxt;
  logic                  q_act_r, q_act_nxt;

  logic [WORD_W-1:0]     mem_r [DEPTH];
  logic                  mem_we;
  logic [WORD_W-1:0]     mem_wdata;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  logic              cs_act;
  logic              awake;
  logic [KW-1:0]     step_adv;
  logic [KW-1:0]     burst_lo;
  logic [WORD_W-1:0] in_word;
  logic [WORD_W-1:0] rd_word;
  logic [WORD_W-1:0] wr_word;
  logic              bypass;

  assign cs_act   = ~chip_sel_a_n & chip_sel_b & ~chip_sel_c_n;
  // Sleep only acts while high; the pin idles low
  assign awake    = (sl_r == pbsp_pkg::SL_AWAKE) & ~sleep_req;
  assign step_adv = KW'(step_r + pbsp_pkg::BURST_STEP);

  // Next address in the burst group
  pbsp_burst_addr #(
    .W       (KW)
  ) u_burst (
    .start   (base_r[KW-1:0]),
    .step    (step_adv),
    .order   (order_r),
    .addr_lo (burst_lo)
  );

  // Lanes carry a data byte with its parity bit above it
  genvar gl;
  generate
    for (gl = 0; gl < LANES; gl++) begin : g_lane
      assign in_word[gl*LW +: LW]   = {parity_in[gl], dq_in[gl*BW +: BW]};
      assign dq_out[gl*BW +: BW]    = q_r[gl*LW +: BW];
      assign parity_out[gl]         = q_r[gl*LW + BW];
    end
  endgenerate

  // Unmasked lanes take new data, parity included
  function automatic logic [WORD_W-1:0] lane_merge(
    input logic [WORD_W-1:0] old_w,
    input logic [WORD_W-1:0] new_w,
    input logic [LANES-1:0]  mask_n
  );
    logic [WORD_W-1:0] r;
    r = old_w;
    for (int i = 0; i < LANES; i++) begin
      if (!mask_n[i]) begin
        r[i*LW +: LW] = new_w[i*LW +: LW];
      end
    end
    return r;
  endfunction

  // ----------------------------------------------------------------
  // Sleep sequencer
  // ----------------------------------------------------------------
  always_comb begin
    sl_nxt     = sl_r;
    sl_cnt_nxt = sl_cnt_r;
    unique case (sl_r)
      pbsp_pkg::SL_AWAKE: begin
        if (sleep_req) begin
          sl_nxt     = pbsp_pkg::SL_ENTER;
          sl_cnt_nxt = '0;
        end
      end
      pbsp_pkg::SL_ENTER: begin
        // Two cycles to reach low power
        if (!sleep_req) begin
          sl_nxt     = pbsp_pkg::SL_WAKE;
          sl_cnt_nxt = '0;
        end else if (sl_cnt_r == ENTRY_LAST) begin
          sl_nxt     = pbsp_pkg::SL_ASLEEP;
        end else begin
          sl_cnt_nxt = CW'(sl_cnt_r + 1'b1);
        end
      end
      pbsp_pkg::SL_ASLEEP: begin
        if (!sleep_req) begin
          sl_nxt     = pbsp_pkg::SL_WAKE;
          sl_cnt_nxt = '0;
        end
      end
      pbsp_pkg::SL_WAKE: begin
        // Two cycles to leave low power
        if (sleep_req) begin
          sl_nxt     = pbsp_pkg::SL_ENTER;
          sl_cnt_nxt = '0;
        end else if (sl_cnt_r == REC_LAST) begin
          sl_nxt     = pbsp_pkg::SL_AWAKE;
        end else begin
          sl_cnt_nxt = CW'(sl_cnt_r + 1'b1);
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      sl_r     <= pbsp_pkg::SL_AWAKE;
      sl_cnt_r <= '0;
    end else begin
      sl_r     <= sl_nxt;
      sl_cnt_r <= sl_cnt_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Command capture, burst counter and pipeline
  // ----------------------------------------------------------------
  always_comb begin
    rd_word = mem_r[s1_addr_r];
    bypass  = s2_r.valid & s2_r.write & (s2_addr_r == s1_addr_r);

    base_nxt    = base_r;
    step_nxt    = step_r;
    order_nxt   = order_r;
    burst_nxt   = burst_r;
    s1_nxt      = s1_r;
    s1_addr_nxt = s1_addr_r;
    s1_mask_nxt = s1_mask_r;
    s2_nxt      = s2_r;
    s2_addr_nxt = s2_addr_r;
    s2_mask_nxt = s2_mask_r;
    q_nxt       = q_r;
    q_act_nxt   = q_act_r;

    if (!awake) begin
      // Pending operations are dropped on sleep entry
      burst_nxt = pbsp_pkg::OP_NONE;
      s1_nxt    = pbsp_pkg::OP_NONE;
      s2_nxt    = pbsp_pkg::OP_NONE;
      q_act_nxt = 1'b0;
    end else if (!clk_gate_n) begin
      // Only a qualified edge moves anything
      if (!burst_step_or_load) begin
        // Load: selects decide deselect, read or write
        base_nxt        = addr;
        step_nxt        = pbsp_pkg::BURST_FIRST;
        order_nxt       = burst_order;
        burst_nxt.valid = cs_act;
        burst_nxt.write = ~write_sel_n;
        s1_nxt.valid    = cs_act;
        s1_nxt.write    = ~write_sel_n;
        s1_addr_nxt     = addr;
      end else begin
        // Continue: selects and write select ignored
        step_nxt    = step_adv;
        s1_nxt      = burst_r;
        s1_addr_nxt = {base_r[ADDR_W-1:KW], burst_lo};
      end
      // Mask sampled on every beat's address edge
      s1_mask_nxt = byte_lane_mask_n;
      // Second stage waits for the write data phase
      s2_nxt      = s1_r;
      s2_addr_nxt = s1_addr_r;
      s2_mask_nxt = s1_mask_r;
      // Output register loads one edge after the address
      if (s1_r.valid && !s1_r.write) begin
        q_nxt = bypass ? lane_merge(rd_word, in_word, s2_mask_r) : rd_word;
      end
      // Writes and deselects float the pins on the next edge
      q_act_nxt = s1_r.valid & ~s1_r.write;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      // Comes up deselected with outputs off
      base_r    <= '0;
      step_r    <= pbsp_pkg::BURST_FIRST;
      order_r   <= pbsp_pkg::ORDER_LINEAR;
      burst_r   <= pbsp_pkg::OP_NONE;
      s1_r      <= pbsp_pkg::OP_NONE;
      s1_addr_r <= '0;
      s1_mask_r <= '1;
      s2_r      <= pbsp_pkg::OP_NONE;
      s2_addr_r <= '0;
      s2_mask_r <= '1;
      q_r       <= '0;
      q_act_r   <= 1'b0;
    end else begin
      base_r    <= base_nxt;
      step_r    <= step_nxt;
      order_r   <= order_nxt;
      burst_r   <= burst_nxt;
      s1_r      <= s1_nxt;
      s1_addr_r <= s1_addr_nxt;
      s1_mask_r <= s1_mask_nxt;
      s2_r      <= s2_nxt;
      s2_addr_r <= s2_addr_nxt;
      s2_mask_r <= s2_mask_nxt;
      q_r       <= q_nxt;
      q_act_r   <= q_act_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Array write
  // ----------------------------------------------------------------
  always_comb begin
    wr_word = mem_r[s2_addr_r];
    // Data taken on the second edge; all-high mask aborts
    mem_we    = awake & ~clk_gate_n & s2_r.valid & s2_r.write
              & ~(&s2_mask_r);
    mem_wdata = lane_merge(wr_word, in_word, s2_mask_r);
  end

  // Contents survive reset and sleep
  always_ff @(posedge clk) begin
    if (mem_we) begin
      mem_r[s2_addr_r] <= mem_wdata;
    end
  end

  // ----------------------------------------------------------------
  // Pin drive
  // ----------------------------------------------------------------
  // Read drive needs the enable low and an active read beat
  always_comb begin
    dq_oe     = q_act_r & ~out_en_n & ~sleep_req
              & (sl_r == pbsp_pkg::SL_AWAKE);
    parity_oe = dq_oe;
  end

endmodule

/* File: pbsp_ctrl_model.sv */
/*
  Controller-side bus model: resolves the shared data and parity pins.
  Assumes the bench sets drv_en and drv_d just after a clock edge.
*/
`timescale 1ns/1ns
module pbsp_ctrl_model (
  // Clock
  input  wire logic        clk,
  // Bench request
  input  wire logic        drv_en,
  input  wire logic [35:0] drv_d,
  // Port side
  input  wire logic [31:0] dq_out,
  input  wire logic [3:0]  par_out,
  input  wire logic        dq_oe,
  // Resolved pins, parity on top
  output logic      [35:0] bus
);
  logic [35:0] last_r;

  // Released bus toggles every cycle so stale data never looks valid
  always_comb begin
    if (dq_oe)
      bus = {par_out, dq_out};
    else if (drv_en)
      bus = drv_d;
    else
      bus = ~last_r;
  end

  always_ff @(posedge clk) begin
    last_r <= bus;
  end
endmodule

/* File: pbsp_port_props.sv */
/*
  Concurrent checks on the pins of the burst SRAM port.
  Assumes binding into pbsp_port; one clock, synchronous reset.
*/
`timescale 1ns/1ns
module pbsp_port_props #(
  parameter int LANES = 4
) (
  input wire logic               clk,
  input wire logic               reset,
  input wire logic               clk_gate_n,
  input wire logic               chip_sel_a_n,
  input wire logic               chip_sel_b,
  input wire logic               chip_sel_c_n,
  input wire logic               burst_step_or_load,
  input wire logic               write_sel_n,
  input wire logic               out_en_n,
  input wire logic               sleep_req,
  input wire logic [LANES*8-1:0] dq_out,
  input wire logic               dq_oe,
  input wire logic               parity_oe
);
  logic [2:0] awake_r;
  logic [2:0] awake_nxt;
  logic       qual;
  logic       sel;
  logic       adv;

  // Cycles since sleep release, saturating; ops counted only when full
  always_comb begin
    awake_nxt = awake_r;
    if (reset)
      awake_nxt = 3'h4;
    else if (sleep_req)
      awake_nxt = 3'h0;
    else if (awake_r != 3'h4)
      awake_nxt = awake_r + 3'h1;
  end

  always_ff @(posedge clk) begin
    awake_r <= awake_nxt;
  end

  assign qual = !clk_gate_n && !sleep_req && awake_r == 3'h4;
  assign sel  = !chip_sel_a_n && chip_sel_b && !chip_sel_c_n;
  assign adv  = qual && burst_step_or_load;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  sequence s_ld_rd;
    qual && !burst_step_or_load && sel && write_sel_n;
  endsequence
  sequence s_ld_wr;
    qual && !burst_step_or_load && sel && !write_sel_n;
  endsequence
  sequence s_oe_ok;
    !out_en_n && !sleep_req;
  endsequence

  a_read_drives: assert property (s_ld_rd ##1 qual ##1 s_oe_ok |-> dq_oe)
    else $error("read beat not driven");
  a_write_floats: assert property (s_ld_wr ##1 qual |=> !dq_oe)
    else $error("pins driven in write data phase");
  a_desel_floats: assert property (qual && !burst_step_or_load && !sel ##1 qual |=> !dq_oe)
    else $error("pins driven after deselect");
  a_oe_gates: assert property (out_en_n |-> !dq_oe && !parity_oe)
    else $error("pins driven with output enable off");
  a_sleep_off: assert property (sleep_req |-> !dq_oe)
    else $error("pins driven while asleep");
  a_reset_off: assert property ($fell(reset) |-> !dq_oe && dq_out == '0)
    else $error("outputs not idle after reset");
  a_stall_holds: assert property (!clk_gate_n == 1'b0 && !sleep_req && awake_r == 3'h4
    |=> $stable(dq_out))
    else $error("output register moved on stalled edge");
  a_stall_oe: assert property (clk_gate_n && awake_r == 3'h4 ##1 $stable(out_en_n) && !sleep_req
    |-> $stable(dq_oe))
    else $error("drive state moved on stalled edge");
  a_rd_burst: assert property (s_ld_rd ##1 adv ##1 qual ##1 s_oe_ok |-> dq_oe)
    else $error("read burst beat not driven");
  a_wr_burst: assert property (s_ld_wr ##1 adv ##1 qual |=> !dq_oe)
    else $error("write burst beat drove pins");
endmodule

bind pbsp_port pbsp_port_props #(.LANES(LANES)) u_pbsp_port_props (
  .clk(clk), .reset(reset), .clk_gate_n(clk_gate_n), .chip_sel_a_n(chip_sel_a_n),
  .chip_sel_b(chip_sel_b), .chip_sel_c_n(chip_sel_c_n), .burst_step_or_load(burst_step_or_load),
  .write_sel_n(write_sel_n), .out_en_n(out_en_n), .sleep_req(sleep_req), .dq_out(dq_out),
  .dq_oe(dq_oe), .parity_oe(parity_oe)
);

/* File: testbench.sv */
/*
  Self-checking bench for the burst SRAM port with random pin traffic.
  Assumes the package, port, checker and bus model are compiled first.
*/
`timescale 1ns/1ns
module testbench;
  logic        clk = 1'b0, reset = 1'b1, clk_gate_n = 1'b0, burst_step_or_load = 1'b0;
  logic        chip_sel_a_n = 1'b1, chip_sel_b = 1'b0, chip_sel_c_n = 1'b1;
  logic        write_sel_n = 1'b1, burst_order = 1'b0, out_en_n = 1'b0, sleep_req = 1'b0;
  logic [3:0]  byte_lane_mask_n = 4'hf, parity_out;
  logic [5:0]  addr = 6'h00, base, rd_a, w1_a, w2_a, a;
  logic [31:0] dq_out, seed = 32'h96f70040;
  logic        dq_oe, parity_oe, drv_en = 1'b0, rd_v, w1_v, w2_v, chk_v, bv, bw, ord;
  logic [35:0] bus, drv_d = 36'h0, mem [64];
  logic [3:0]  w1_m, w2_m;
  logic [1:0]  k;
  logic [36:0] expq [$];
  logic [36:0] e;
  int          fail_count = 0, checks_done = 0;
  logic        desel = 1'b0, ld;

  always #2 clk = ~clk;

  pbsp_port #(.ADDR_W(6)) u_pbsp_port (
    .clk(clk), .reset(reset), .clk_gate_n(clk_gate_n), .chip_sel_a_n(chip_sel_a_n),
    .chip_sel_b(chip_sel_b), .chip_sel_c_n(chip_sel_c_n), .burst_step_or_load(burst_step_or_load),
    .write_sel_n(write_sel_n), .byte_lane_mask_n(byte_lane_mask_n), .addr(addr),
    .burst_order(burst_order), .out_en_n(out_en_n), .sleep_req(sleep_req), .dq_in(bus[31:0]),
    .dq_out(dq_out), .dq_oe(dq_oe), .parity_in(bus[35:32]), .parity_out(parity_out),
    .parity_oe(parity_oe));

  pbsp_ctrl_model u_pbsp_ctrl_model (
    .clk(clk), .drv_en(drv_en), .drv_d(drv_d), .dq_out(dq_out), .par_out(parity_out),
    .dq_oe(dq_oe), .bus(bus));

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction

  task automatic check(input logic [36:0] seen, input logic [36:0] want);
    checks_done++;
    if (seen !== want) begin
      fail_count++;
      $display("MISMATCH t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask

  task automatic finish_test;
    $display("checks=%0d mismatches=%0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Drive one cycle of pins; deselects pick which selects go inactive
  task automatic drive(input logic g, l, s, w, input logic [5:0] ad, input logic [3:0] m);
    @(posedge clk);
    clk_gate_n <= g;
    burst_step_or_load <= l;
    {chip_sel_a_n, chip_sel_b, chip_sel_c_n} <= 3'b010 ^ (s ? 3'h0 :
      (seed[31:30] == 2'h0 ? 3'h4 : {1'b0, seed[31:30]}));
    write_sel_n <= !w;
    addr <= ad;
    byte_lane_mask_n <= m;
    burst_order <= seed[29];
    out_en_n <= seed[28] & seed[27];
  endtask

  // ----------------------------------------------------------------
  // Reference model: notes expected beats
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (reset || sleep_req) begin
      {rd_v, w1_v, w2_v, chk_v} <= 4'h0;
      bv = 1'b0;
      drv_en <= 1'b0;
    end else if (!clk_gate_n) begin
      for (int i = 0; i < 4; i++)
        if (w2_v && !w2_m[i]) begin
          mem[w2_a][8*i+:8] = drv_d[8*i+:8];
          mem[w2_a][32+i] = drv_d[32+i];
        end
      expq.push_back({rd_v, mem[rd_a]});
      chk_v <= 1'b1;
      if (!burst_step_or_load) begin
        bv = !chip_sel_a_n && chip_sel_b && !chip_sel_c_n;
        bw = !write_sel_n;
        base = addr;
        ord = burst_order;
        k = 2'h0;
      end else
        k = k + 2'h1;
      a = {base[5:2], ord ? base[1:0] ^ k : base[1:0] + k};
      rd_v <= bv && !bw;
      rd_a <= a;
      w1_v <= bv && bw;
      w1_a <= a;
      w1_m <= byte_lane_mask_n;
      {w2_v, w2_a, w2_m} <= {w1_v, w1_a, w1_m};
      drv_en <= w1_v;
      drv_d <= {seed[7:4], xs(seed)};
    end else
      chk_v <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Output watcher
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (chk_v && expq.size() > 0) begin
      e = expq.pop_front();
      check({dq_oe, parity_oe}, {2{e[36] && !out_en_n}});
      // Output register holds every read beat, whatever the enable
      if (e[36])
        check({parity_out, dq_out}, e[35:0]);
    end
  end

  initial begin
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    for (int i = 0; i < 64; i++) begin
      seed = xs(seed);
      drive(1'b0, 1'b0, 1'b1, 1'b1, i[5:0], 4'h0);
    end
    for (int i = 0; i < 3000; i++) begin
      seed = xs(seed);
      ld = !seed[5] || desel;
      drive(seed[3:0] == 4'h0, !ld, seed[7:6] != 2'h0, seed[8], seed[21:16], seed[25:22]);
      if (seed[3:0] != 4'h0)
        desel = ld && seed[7:6] == 2'h0;
    end
    for (int i = 0; i < 18; i++) begin
      drive(1'b0, 1'b0, 1'b0, 1'b0, 6'h00, 4'hf);
      sleep_req <= i > 3 && i < 10;
    end
    for (int i = 0; i < 64; i++)
      drive(1'b0, 1'b0, 1'b1, 1'b0, i[5:0], 4'hf);
    repeat (4) drive(1'b0, 1'b0, 1'b0, 1'b0, 6'h00, 4'hf);
    finish_test();
  end

  initial begin
    #40000;
    fail_count++;
    finish_test();
  end
endmodule
